// ---- core/qsps_pkg.sv ----
// Shared constants and the pattern stepping function for the serial status and pattern-test block.
// Assumes a 32-bit APB register bus with one register per aligned word.
package qsps_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h12;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h13;
   localparam logic [7:0] IDX_RX_ERR = 8'h15;
   localparam logic [7:0] IDX_PAT_CTRL = 8'h17;
   localparam logic [7:0] IDX_PAT_LOW = 8'h18;
   localparam logic [7:0] IDX_PAT_HIGH = 8'h19;
   localparam logic [7:0] IDX_GLOBAL_CTRL = 8'h1A;
   // Interrupt status and enable bit positions.
   localparam int ST_SPEED = 14;
   localparam int ST_DUPLEX = 13;
   localparam int ST_PAGE = 12;
   localparam int ST_ANEG = 11;
   localparam int ST_LINK = 10;
   localparam int ST_SYMBOL = 9;
   localparam int ST_FALSE_CARRIER = 8;
   localparam int ST_FIFO = 7;
   localparam logic [15:0] IRQ_FIELD_MASK = 16'h7F80;
   // Pattern control bit positions.
   localparam int PC_CHK_POL = 7;
   localparam int PC_GEN_POL = 6;
   localparam int PC_LOCK_MODE = 5;
   localparam int PC_CLEAR = 4;
   localparam int PC_SEL_HI = 3;
   localparam int PC_SEL_LO = 2;
   localparam int PC_CHK_EN = 1;
   localparam int PC_GEN_EN = 0;
   localparam logic [15:0] PAT_CTRL_RESET = 16'h0000;
   localparam logic [15:0] PAT_CTRL_SOFT_CLEAR = 16'h0013;
   // Global control bit positions.
   localparam int GC_RESET = 15;
   localparam int GC_REFCLK = 14;
   localparam int GC_IN_POL = 13;
   localparam int GC_OUT_POL = 12;
   localparam int GC_PWRDN = 11;
   localparam int GC_RSVD10 = 10;
   localparam int GC_LOOPBACK = 9;
   localparam int GC_DISPARITY = 3;
   localparam logic [15:0] GLOBAL_CTRL_RESET = 16'h3002;
   localparam logic [15:0] GLOBAL_CTRL_SOFT_CLEAR = 16'h0600;
   localparam logic [2:0] STRAP_POWER_DOWN = 3'h1;
   // Pattern selections.
   localparam logic [1:0] SEL_PRBS7 = 2'h0;
   localparam logic [1:0] SEL_PRBS23 = 2'h1;
   localparam logic [1:0] SEL_PRBS31 = 2'h2;
   localparam logic [1:0] SEL_ALT = 2'h3;
   localparam logic [9:0] ALT_PATTERN = 10'h2AA;
   localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;
   localparam logic [4:0] LOCK_RUN = 5'h10;
   localparam logic [31:0] PAT_COUNT_MAX = 32'hFFFFFFFF;
   localparam logic [15:0] RX_COUNT_MAX = 16'hFFFF;

   // Advances the shift register by one 10-bit symbol, MSB first (SEL_ALT holds it), and returns {state, predicted word}.
   // With use_rx set the received bits are shifted in, which makes the checker self-synchronising.
   function automatic logic [40:0] prbs_advance(input logic [30:0] st, input logic [1:0] sel,
                                               input logic [9:0] rx, input logic use_rx);
      logic [30:0] s;
      logic [9:0] pw;
      logic fb;
      s = st;
      pw = 10'h000;
      fb = 1'b0;
      for (int i = 9; i >= 0; i--) begin
         case (sel)
            SEL_PRBS7: fb = s[6] ^ s[5];
            SEL_PRBS23: fb = s[22] ^ s[17];
            default: fb = s[30] ^ s[27];
         endcase
         pw[i] = fb;
         s = {s[29:0], (use_rx ? rx[i] : fb)};
      end
      if (sel == SEL_ALT) begin
         prbs_advance = {st, ALT_PATTERN};
      end else begin
         prbs_advance = {s, pw};
      end
   endfunction
endpackage

// ---- core/pattern_generator.sv ----
// Pattern generator producing one 10-bit symbol per clock.
// Assumes the enable and selection come from the control register of the parent.
`timescale 1ns/1ns
module pattern_generator
   import qsps_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic [1:0] sel,
   input wire logic invert_n,
   output logic [9:0] gen_symbol
);
   logic [30:0] state_r, state_nxt;
   logic [9:0] sym_r, sym_nxt;
   logic [40:0] step;

   always_comb begin
      step = prbs_advance(state_r, sel, 10'h000, 1'b0);
      state_nxt = state_r;
      sym_nxt = 10'h000;
      if (enable) begin
         state_nxt = step[40:10];
         sym_nxt = invert_n ? step[9:0] : ~step[9:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= PRBS_SEED;
         sym_r <= 10'h000;
      end else begin
         state_r <= state_nxt;
         sym_r <= sym_nxt;
      end
   end

   assign gen_symbol = sym_r;
endmodule

// ---- core/pattern_checker.sv ----
// Self-synchronising pattern checker with lock detection and a 32-bit error count.
// Assumes one received 10-bit symbol per clock, already polarity corrected by the parent.
`timescale 1ns/1ns
module pattern_checker
   import qsps_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic [1:0] sel,
   input wire logic invert_n,
   input wire logic lock_mode,
   input wire logic clear,
   input wire logic [9:0] rx_symbol,
   output logic locked,
   output logic [31:0] err_count
);
   logic [30:0] state_r, state_nxt;
   logic [4:0] run_r, run_nxt;
   logic locked_r, locked_nxt;
   logic [31:0] count_r, count_nxt;
   logic [40:0] step;
   logic [9:0] rx;
   logic err;

   always_comb begin
      rx = invert_n ? rx_symbol : ~rx_symbol;
      step = prbs_advance(state_r, sel, rx, 1'b1);
      err = (step[9:0] != rx);
      state_nxt = state_r;
      run_nxt = run_r;
      locked_nxt = locked_r;
      count_nxt = count_r;
      if (!enable) begin
         run_nxt = 5'h00;
         locked_nxt = 1'b0;
      end else begin
         state_nxt = step[40:10];
         if (err) begin
            run_nxt = 5'h00;
         end else if (run_r != LOCK_RUN) begin
            run_nxt = run_r + 5'h01;
         end
         if (run_r == LOCK_RUN) begin
            locked_nxt = 1'b1;
         end
         if (err && (!lock_mode || locked_r) && count_r != PAT_COUNT_MAX) begin
            count_nxt = count_r + 32'h00000001;
         end
      end
      if (clear) begin
         count_nxt = 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= PRBS_SEED;
         run_r <= 5'h00;
         locked_r <= 1'b0;
         count_r <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         run_r <= run_nxt;
         locked_r <= locked_nxt;
         count_r <= count_nxt;
      end
   end

   assign locked = locked_r;
   assign err_count = count_r;
endmodule

// ---- core/quad_serial_status_prbs_control.sv ----
// Status, error counting, pattern test and global control for the quad serial MAC-side interface.
// Assumes an APB master on pclk, event inputs synchronous to pclk and one 10-bit symbol per clock.
`timescale 1ns/1ns
module quad_serial_status_prbs_control
   import qsps_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [2:0] mode_strap,
   input wire logic speed_change_event,
   input wire logic duplex_change_event,
   input wire logic page_received_event,
   input wire logic autoneg_done_event,
   input wire logic link_change_event,
   input wire logic fifo_error_event,
   input wire logic rx_false_carrier,
   input wire logic rx_code_error,
   input wire logic rx_disparity_error,
   input wire logic [9:0] serial_input_pair,
   input wire logic [9:0] tx_symbol,
   output logic [9:0] serial_output_pair,
   output logic symbol_error_out,
   input wire logic [3:0] port_power_request,
   output logic [3:0] port_power_down,
   output logic common_power_down,
   output logic soft_reset_pulse,
   output logic ref_clk_select,
   output logic pattern_locked
);
   logic [15:0] irq_enable_r, irq_enable_nxt;
   logic [15:0] irq_status_r, irq_status_nxt;
   logic [15:0] rx_err_r, rx_err_nxt;
   logic [15:0] pat_ctrl_r, pat_ctrl_nxt;
   logic [15:0] pat_high_r, pat_high_nxt;
   logic [15:0] global_ctrl_r, global_ctrl_nxt;
   logic ref_clk_r, ref_clk_nxt;
   logic strap_done_r, strap_done_nxt;
   logic soft_reset_r, soft_reset_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [9:0] out_r, out_nxt;
   logic sym_err_r, sym_err_nxt;

   logic [7:0] index;
   logic mapped;
   logic setup_read;
   logic access_write;
   logic [15:0] wdata;
   logic [15:0] events;
   logic [15:0] rd_word;
   logic symbol_error;
   logic rx_err_event;
   logic [9:0] rx_corrected;
   logic [9:0] gen_symbol;
   logic [31:0] pat_count;
   logic chk_clear;

   // Address decode; offsets are word indices so the low two address bits must be zero.
   always_comb begin
      index = {2'b00, paddr[7:2]};
      if (paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end else if (index == IDX_IRQ_ENABLE) begin
         mapped = 1'b1;
      end else if (index == IDX_IRQ_STATUS) begin
         mapped = 1'b1;
      end else if (index == IDX_RX_ERR) begin
         mapped = 1'b1;
      end else if (index == IDX_PAT_CTRL) begin
         mapped = 1'b1;
      end else if (index == IDX_PAT_LOW) begin
         mapped = 1'b1;
      end else if (index == IDX_PAT_HIGH) begin
         mapped = 1'b1;
      end else if (index == IDX_GLOBAL_CTRL) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   // Reads act at the setup edge, where the data is also captured, so a read's clear and the
   // returned value always refer to the same instant. Writes act at the access edge.
   assign setup_read = psel && !penable && !pwrite && mapped;
   assign access_write = psel && penable && pwrite && mapped;
   assign wdata = pwdata[15:0];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_comb begin
      rx_corrected = global_ctrl_r[GC_IN_POL] ? serial_input_pair : ~serial_input_pair;
      symbol_error = rx_code_error || (global_ctrl_r[GC_DISPARITY] && rx_disparity_error);
      rx_err_event = symbol_error || rx_false_carrier;
      events = 16'h0000;
      events[ST_SPEED] = speed_change_event;
      events[ST_DUPLEX] = duplex_change_event;
      events[ST_PAGE] = page_received_event;
      events[ST_ANEG] = autoneg_done_event;
      events[ST_LINK] = link_change_event;
      events[ST_SYMBOL] = symbol_error;
      events[ST_FALSE_CARRIER] = rx_false_carrier;
      events[ST_FIFO] = fifo_error_event;
   end

   // Read multiplexer.
   always_comb begin
      if (index == IDX_IRQ_ENABLE) begin
         rd_word = irq_enable_r;
      end else if (index == IDX_IRQ_STATUS) begin
         rd_word = irq_status_r;
      end else if (index == IDX_RX_ERR) begin
         rd_word = rx_err_r;
      end else if (index == IDX_PAT_CTRL) begin
         rd_word = pat_ctrl_r;
      end else if (index == IDX_PAT_LOW) begin
         rd_word = pat_count[15:0];
      end else if (index == IDX_PAT_HIGH) begin
         rd_word = pat_high_r;
      end else if (index == IDX_GLOBAL_CTRL) begin
         rd_word = global_ctrl_r;
      end else begin
         rd_word = 16'h0000;
      end
   end

   // Register file next state.
   always_comb begin
      irq_enable_nxt = irq_enable_r;
      irq_status_nxt = irq_status_r;
      rx_err_nxt = rx_err_r;
      pat_ctrl_nxt = pat_ctrl_r;
      pat_high_nxt = pat_high_r;
      global_ctrl_nxt = global_ctrl_r;
      ref_clk_nxt = ref_clk_r;
      strap_done_nxt = 1'b1;
      soft_reset_nxt = 1'b0;
      prdata_nxt = prdata_r;
      chk_clear = pat_ctrl_r[PC_CLEAR];

      if (!strap_done_r) begin
         global_ctrl_nxt[GC_PWRDN] = (mode_strap == STRAP_POWER_DOWN);
      end

      if (setup_read) begin
         prdata_nxt = {16'h0000, rd_word};
         if (index == IDX_IRQ_STATUS) begin
            irq_status_nxt = 16'h0000;
         end
         if (index == IDX_RX_ERR) begin
            rx_err_nxt = 16'h0000;
         end
         if (index == IDX_PAT_LOW) begin
            pat_high_nxt = pat_count[31:16];
         end
      end

      if (access_write) begin
         if (index == IDX_IRQ_ENABLE) begin
            irq_enable_nxt = wdata & IRQ_FIELD_MASK;
         end
         if (index == IDX_PAT_CTRL) begin
            pat_ctrl_nxt = wdata;
         end
         if (index == IDX_GLOBAL_CTRL) begin
            global_ctrl_nxt = wdata;
            global_ctrl_nxt[GC_RESET] = 1'b0;
            soft_reset_nxt = wdata[GC_RESET];
         end
      end

      // The clear-counter bit acts for one cycle and then drops by itself.
      if (pat_ctrl_r[PC_CLEAR]) begin
         pat_ctrl_nxt[PC_CLEAR] = access_write && (index == IDX_PAT_CTRL) && wdata[PC_CLEAR];
         pat_high_nxt = 16'h0000;
      end

      // Software reset: status clears, self-clearing and reset-cleared controls drop,
      // and the pending reference clock choice takes effect.
      if (soft_reset_r) begin
         irq_status_nxt = 16'h0000;
         pat_ctrl_nxt = pat_ctrl_nxt & ~PAT_CTRL_SOFT_CLEAR;
         global_ctrl_nxt = global_ctrl_nxt & ~GLOBAL_CTRL_SOFT_CLEAR;
         ref_clk_nxt = global_ctrl_r[GC_REFCLK];
      end

      // Events set after any clear so that an event in the clearing cycle is kept.
      irq_status_nxt = irq_status_nxt | (events & IRQ_FIELD_MASK);
      if (rx_err_event && rx_err_nxt != RX_COUNT_MAX) begin
         rx_err_nxt = rx_err_nxt + 16'h0001;
      end
   end

   // Outgoing symbol path and symbol error flag.
   always_comb begin
      if (global_ctrl_r[GC_LOOPBACK]) begin
         out_nxt = serial_input_pair;
      end else if (pat_ctrl_r[PC_GEN_EN]) begin
         out_nxt = gen_symbol;
      end else begin
         out_nxt = tx_symbol;
      end
      if (!global_ctrl_r[GC_LOOPBACK] && !global_ctrl_r[GC_OUT_POL]) begin
         out_nxt = ~out_nxt;
      end
      sym_err_nxt = symbol_error;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_r <= 16'h0000;
         irq_status_r <= 16'h0000;
         rx_err_r <= 16'h0000;
         pat_ctrl_r <= PAT_CTRL_RESET;
         pat_high_r <= 16'h0000;
         global_ctrl_r <= GLOBAL_CTRL_RESET;
         ref_clk_r <= 1'b0;
         strap_done_r <= 1'b0;
         soft_reset_r <= 1'b0;
         prdata_r <= 32'h00000000;
         out_r <= 10'h000;
         sym_err_r <= 1'b0;
      end else begin
         irq_enable_r <= irq_enable_nxt;
         irq_status_r <= irq_status_nxt;
         rx_err_r <= rx_err_nxt;
         pat_ctrl_r <= pat_ctrl_nxt;
         pat_high_r <= pat_high_nxt;
         global_ctrl_r <= global_ctrl_nxt;
         ref_clk_r <= ref_clk_nxt;
         strap_done_r <= strap_done_nxt;
         soft_reset_r <= soft_reset_nxt;
         prdata_r <= prdata_nxt;
         out_r <= out_nxt;
         sym_err_r <= sym_err_nxt;
      end
   end

   pattern_generator u_gen (
      .pclk(pclk),
      .presetn(presetn),
      .enable(pat_ctrl_r[PC_GEN_EN]),
      .sel(pat_ctrl_r[PC_SEL_HI:PC_SEL_LO]),
      .invert_n(pat_ctrl_r[PC_GEN_POL]),
      .gen_symbol(gen_symbol)
   );

   pattern_checker u_chk (
      .pclk(pclk),
      .presetn(presetn),
      .enable(pat_ctrl_r[PC_CHK_EN]),
      .sel(pat_ctrl_r[PC_SEL_HI:PC_SEL_LO]),
      .invert_n(pat_ctrl_r[PC_CHK_POL]),
      .lock_mode(pat_ctrl_r[PC_LOCK_MODE]),
      .clear(chk_clear),
      .rx_symbol(rx_corrected),
      .locked(pattern_locked),
      .err_count(pat_count)
   );

   assign prdata = prdata_r;
   assign irq = |(irq_status_r & irq_enable_r);
   assign serial_output_pair = out_r;
   assign symbol_error_out = sym_err_r;
   assign common_power_down = global_ctrl_r[GC_PWRDN];
   assign port_power_down = global_ctrl_r[GC_PWRDN] ? 4'hF : port_power_request;
   assign soft_reset_pulse = soft_reset_r;
   assign ref_clk_select = ref_clk_r;
endmodule

// ---- sim/serial_partner.sv ----
// Far-side port model that answers on the serial link in step with pclk.
// Assumes mode 0 echoes, mode 1 corrupts every symbol, mode 2 sends a changing pattern.
`timescale 1ns/1ns
module serial_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] mode,
   input wire logic [9:0] serial_output_pair,
   output logic [9:0] serial_input_pair
);
   logic [9:0] sym_r, sym_nxt;
   always_comb begin
      case (mode)
         2'h1: sym_nxt = ~serial_output_pair;
         2'h2: sym_nxt = sym_r + 10'h0B7;
         default: sym_nxt = serial_output_pair;
      endcase
   end
   // Symbols are launched on pclk so transmit and receive stay synchronous.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sym_r <= 10'h155;
      end else begin
         sym_r <= sym_nxt;
      end
   end
   assign serial_input_pair = sym_r;
endmodule

// ---- sim/qsps_checker.sv ----
// Port-level assertions for the serial status block.
// Assumes zero-wait APB writes that take effect at the access edge.
`timescale 1ns/1ns
module qsps_checker
   import qsps_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic irq,
   input wire logic rx_code_error,
   input wire logic rx_disparity_error,
   input wire logic [9:0] serial_input_pair,
   input wire logic [9:0] serial_output_pair,
   input wire logic symbol_error_out,
   input wire logic [3:0] port_power_request,
   input wire logic [3:0] port_power_down,
   input wire logic common_power_down,
   input wire logic soft_reset_pulse,
   input wire logic ref_clk_select,
   input wire logic pattern_locked
);
   logic [15:0] gc_r, gc_nxt, en_r, en_nxt;
   logic wr_gc, wr_en, wr_pc;
   assign wr_gc = psel && penable && pwrite && paddr == 8'h68;
   assign wr_en = psel && penable && pwrite && paddr == 8'h48;
   assign wr_pc = psel && penable && pwrite && paddr == 8'h5C;
   always_comb begin
      gc_nxt = wr_gc ? pwdata[15:0] : gc_r;
      en_nxt = wr_en ? pwdata[15:0] : en_r;
      if (soft_reset_pulse) begin
         gc_nxt[10:9] = 2'h0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gc_r <= GLOBAL_CTRL_RESET;
         en_r <= 16'h0000;
      end else begin
         gc_r <= gc_nxt;
         en_r <= en_nxt;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_sw_req;
      wr_gc && pwdata[GC_RESET];
   endsequence
   sequence s_pulse;
      soft_reset_pulse ##1 !soft_reset_pulse;
   endsequence
   a_soft_pulse: assert property (s_sw_req |-> ##[1:2] s_pulse)
      else $error("soft reset pulse missing");
   a_refclk_hold: assert property ($changed(ref_clk_select) |-> soft_reset_pulse || $past(soft_reset_pulse))
      else $error("clock select moved without soft reset");
   a_refclk_take: assert property (soft_reset_pulse |=> ref_clk_select == $past(gc_r[GC_REFCLK]))
      else $error("clock select not taken");
   a_pwr_ports: assert property (port_power_down == (common_power_down ? 4'hF : port_power_request))
      else $error("port power state wrong");
   a_pwr_write: assert property (wr_gc |=> common_power_down == $past(pwdata[GC_PWRDN]))
      else $error("global power down not applied");
   a_loop_raw: assert property (gc_r[GC_LOOPBACK] && $past(gc_r[GC_LOOPBACK])
      |-> serial_output_pair == $past(serial_input_pair))
      else $error("loopback symbol wrong");
   a_code_err: assert property (rx_code_error |=> symbol_error_out)
      else $error("code error not flagged");
   a_sym_quiet: assert property (!rx_code_error && !rx_disparity_error |=> !symbol_error_out)
      else $error("spurious symbol error");
   a_disp_gate: assert property (rx_disparity_error && !rx_code_error
      && gc_r[GC_DISPARITY] == $past(gc_r[GC_DISPARITY]) |=> symbol_error_out == $past(gc_r[GC_DISPARITY]))
      else $error("disparity gating wrong");
   a_irq_mask: assert property (wr_en && pwdata[15:0] == 16'h0000 |=> !irq)
      else $error("masked interrupt high");
   a_irq_raise: assert property (rx_code_error && en_r[ST_SYMBOL] |=> irq)
      else $error("enabled interrupt low");
   a_lock_drop: assert property (wr_pc && !pwdata[PC_CHK_EN] |-> ##[1:3] !pattern_locked)
      else $error("lock kept after disable");
endmodule
bind quad_serial_status_prbs_control qsps_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .irq, .rx_code_error, .rx_disparity_error, .serial_input_pair, .serial_output_pair,
   .symbol_error_out, .port_power_request, .port_power_down, .common_power_down, .soft_reset_pulse,
   .ref_clk_select, .pattern_locked);

// ---- sim/tb_top.sv ----
// Self-checking bench for the serial status block with a far-side partner.
// Assumes the package constants and the zero-wait APB timing of the block.
`timescale 1ns/1ns
module tb_top;
   import qsps_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, code_hold = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rdat;
   logic [14:6] ev_r = 9'h000;
   logic [2:0] mode_strap = 3'h0;
   logic [1:0] pmode = 2'h0;
   logic [9:0] saved;
   logic [19:0] pw;
   logic rerr;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, irq, symbol_error_out, common_power_down, soft_reset_pulse, ref_clk_select;
   wire logic pattern_locked;
   wire logic [9:0] serial_input_pair, serial_output_pair;
   wire logic [3:0] port_power_down;
   int errors = 0, n_tests = 0, cyc = 0;
   quad_serial_status_prbs_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq, .mode_strap, .speed_change_event(ev_r[14]), .duplex_change_event(ev_r[13]),
      .page_received_event(ev_r[12]), .autoneg_done_event(ev_r[11]), .link_change_event(ev_r[10]),
      .fifo_error_event(ev_r[7]), .rx_false_carrier(ev_r[8]), .rx_code_error(ev_r[9] | code_hold),
      .rx_disparity_error(ev_r[6]), .serial_input_pair, .tx_symbol(10'h0F0), .serial_output_pair,
      .symbol_error_out, .port_power_request(4'h5), .port_power_down, .common_power_down, .soft_reset_pulse,
      .ref_clk_select, .pattern_locked);
   serial_partner far_u (.pclk, .presetn, .mode(pmode), .serial_output_pair, .serial_input_pair);
   initial begin
      forever #5 pclk = ~pclk;
   end
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 80000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 16'h0000);
      chk32(rdat, exp);
   endtask
   // Raises one event input for a single cycle and returns after the edge that sees it.
   task automatic pulse(input int b);
      @(posedge pclk);
      ev_r[b] <= 1'b1;
      @(posedge pclk);
      ev_r[b] <= 1'b0;
      #1;
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(8'h68, 32'h3002);
      rd(8'h5C, 32'h0000);
      rd(8'h4C, 32'h0000);
      rd(8'h54, 32'h0000);
      rd(8'h60, 32'h0000);
      rd(8'h64, 32'h0000);
      apb(1'b0, 8'h40, 16'h0000);
      chk1(rerr, 1'b1);
      #1 chk32({22'h0, serial_output_pair}, 32'h00F0);
      apb(1'b1, 8'h68, 16'h2002);
      @(posedge pclk);
      #1 chk32({22'h0, serial_output_pair}, 32'h030F);
      apb(1'b1, 8'h48, 16'h7F80);
      for (int b = 7; b <= 14; b++) begin
         pulse(b);
         chk1(irq, 1'b1);
         rd(8'h4C, 32'h1 << b);
         rd(8'h4C, 32'h0000);
         chk1(irq, 1'b0);
      end
      rd(8'h54, 32'h0002);
      apb(1'b1, 8'h48, 16'h0000);
      pulse(14);
      chk1(irq, 1'b0);
      rd(8'h4C, 32'h4000);
      // The checker sees a constant symbol meanwhile, so every symbol counts and the count carries into the high half.
      apb(1'b1, 8'h5C, 16'h0082);
      code_hold <= 1'b1;
      repeat (65600) @(posedge pclk);
      code_hold <= 1'b0;
      rd(8'h54, 32'hFFFF);
      rd(8'h54, 32'h0000);
      rd(8'h64, 32'h0000);
      apb(1'b0, 8'h60, 16'h0000);
      rd(8'h64, 32'h0001);
      pulse(6);
      rd(8'h54, 32'h0000);
      apb(1'b1, 8'h68, 16'h300A);
      pulse(6);
      rd(8'h54, 32'h0001);
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, 8'h5C, 16'h0000);
         apb(1'b1, 8'h5C, 16'h00C3 | 16'(s << 2));
         repeat (80) @(posedge pclk);
         chk1(pattern_locked, 1'b1);
      end
      // Two output symbols in a row must obey the seven-stage recurrence, oldest bit highest.
      apb(1'b1, 8'h5C, 16'h00C3);
      repeat (5) @(posedge pclk);
      #1 pw[19:10] = serial_output_pair;
      @(posedge pclk);
      #1 pw[9:0] = serial_output_pair;
      for (int j = 0; j < 13; j++) begin
         chk1(pw[j], pw[j + 7] ^ pw[j + 6]);
      end
      apb(1'b1, 8'h5C, 16'h00C0);
      repeat (4) @(posedge pclk);
      chk1(pattern_locked, 1'b0);
      apb(1'b1, 8'h5C, 16'h00CF);
      repeat (20) @(posedge pclk);
      #1 chk32({22'h0, serial_output_pair}, 32'h02AA);
      apb(1'b1, 8'h5C, 16'h00DF);
      repeat (3) @(posedge pclk);
      pmode <= 2'h1;
      repeat (3) @(posedge pclk);
      pmode <= 2'h0;
      repeat (5) @(posedge pclk);
      rd(8'h60, 32'h0003);
      rd(8'h64, 32'h0000);
      apb(1'b1, 8'h5C, 16'h00DF);
      rd(8'h5C, 32'h00CF);
      rd(8'h60, 32'h0000);
      apb(1'b1, 8'h5C, 16'h0000);
      pmode <= 2'h1;
      apb(1'b1, 8'h5C, 16'h00FF);
      repeat (20) @(posedge pclk);
      rd(8'h60, 32'h0000);
      apb(1'b1, 8'h5C, 16'h00CF);
      repeat (10) @(posedge pclk);
      apb(1'b0, 8'h60, 16'h0000);
      chk1(rdat[15:0] != 16'h0000, 1'b1);
      apb(1'b1, 8'h68, 16'h3802);
      #1 chk1(common_power_down, 1'b1);
      chk32({28'h0, port_power_down}, 32'h000F);
      apb(1'b1, 8'h68, 16'h3002);
      #1 chk32({28'h0, port_power_down}, 32'h0005);
      pmode <= 2'h2;
      apb(1'b1, 8'h68, 16'h3202);
      repeat (3) @(posedge pclk);
      #1 saved = serial_input_pair;
      @(posedge pclk);
      #1 chk32({22'h0, serial_output_pair}, {22'h0, saved});
      apb(1'b1, 8'h68, 16'h7202);
      #1 chk1(ref_clk_select, 1'b0);
      pulse(14);
      apb(1'b1, 8'h68, 16'hF202);
      repeat (3) @(posedge pclk);
      #1 chk1(ref_clk_select, 1'b1);
      rd(8'h68, 32'h7002);
      rd(8'h4C, 32'h0000);
      rd(8'h5C, 32'h00CC);
      @(posedge pclk);
      presetn <= 1'b0;
      mode_strap <= 3'h1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(8'h68, 32'h3802);
      end_sim();
   end
endmodule
